// >>> rfbw_access_sm.sv
`timescale 1ns/1ns
// Contract
// R1: Stay idle until remote write condition
// R2: Override or local grant holds second idle
// R3: Idle states grant local requests when locked
// R4: Acknowledge low at once on remote write
// R5: Arbitrate next clock; no grants until termination
// R6: Local data access waits until termination
// R7: Buses float half T-state into arbitration; code floats them from the first arbitration clock (state RFBW_B)
// R8: Ownership high, load wait counters
// R9: Instruction strobe in access start if high
// R10: Command writes control register, delayed effect
// R11: Select 10/11 write program counter bytes
// R12: Select 00 strobes data write, waits
// R13: Instruction bytes paired via holding latch
// R14: High-byte flag cleared by reset, select write; code clears it only on writes selecting instruction memory
// R15: Wait low extends access
// R16: Termination raises acknowledge, keeps ownership
// R17: Remote ends cycle after acknowledge high
// R18: Ownership drops, buses float half T-state
// R19: Increment program counter after high byte
// R20: Hold until condition drops, then idle
// R21: One T-state before taking bus
// R22: Address settles one T-state before strobe
// R23: One clock, sampled each T-state
module rfbw_access_sm
  import rfbw_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        remote_enable,
  input  wire logic        remote_write_strobe_n,
  input  wire logic        cmd,
  input  wire logic        wait_n,
  input  wire logic        local_bus_request,
  input  wire logic        lock,
  input  wire logic        local_data_access,
  input  wire logic [7:0]  ad_in,
  input  wire logic [IW_W-1:0] instr_wait_field,
  input  wire logic [DW_W-1:0] data_wait_field,
  output logic             transfer_acknowledge,
  output logic             local_bus_ownership_n,
  output logic             local_bus_grant,
  output logic             tcu_remote_wait,
  output logic             bus_drive_en,
  output logic             mem_write_n,
  output logic             instr_write_strobe_n,
  output logic [15:0]      instr_word,
  output logic [15:0]      program_counter,
  output logic [7:0]       remote_interface_control_reg,
  output logic             high_byte_flag
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_s1_r;
  logic rst_s2_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire logic rstn = rst_s2_r;

  // ****************************************************************
  // State and decode
  // ****************************************************************
  rfbw_state_t state_r;
  rfbw_state_t state_nxt;
  logic        rwc;
  logic        grant_r;
  logic        float_r;
  logic [7:0]  ric_pend_r;
  logic        ric_pend_v_r;
  logic [7:0]  instr_low_holding_latch_r;
  logic        wrote_hi_r;
  logic        local_override_bit;
  logic [1:0]  ms;
  rfbw_wait_if w ();

  function automatic logic is_access(input rfbw_state_t s);
    return s inside {RFBW_D1, RFBW_D2, RFBW_D3, RFBW_D4, RFBW_D5,
                     RFBW_D6};
  endfunction

  function automatic logic is_idle(input rfbw_state_t s);
    return s inside {RFBW_A1, RFBW_A2};
  endfunction

  assign rwc = remote_enable && !remote_write_strobe_n;   // [R23]
  assign local_override_bit = remote_interface_control_reg[RIC_LOR];
  assign ms  = remote_interface_control_reg[RIC_MS_LSB +: 2];

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      RFBW_A1, RFBW_A2: begin
        if (!rwc) begin
          state_nxt = RFBW_A1;                            // [R1]
        end else if (local_override_bit || grant_r || local_bus_request) begin
          state_nxt = RFBW_A2;                            // [R2]
        end else begin
          state_nxt = RFBW_B;                             // [R5] [R21]
        end
      end
      RFBW_B: state_nxt = RFBW_C;                         // [R8] [R22]
      RFBW_C: begin
        if (cmd) begin
          state_nxt = RFBW_D1;                            // [R10]
        end else begin
          unique case (ms)
            MS_PCLO: state_nxt = RFBW_D2;                 // [R11]
            MS_PCHI: state_nxt = RFBW_D3;                 // [R11]
            MS_DATA_MEMORY: state_nxt = RFBW_D4;                 // [R12]
            MS_INSTRUCTION_MEMORY: begin
              state_nxt = high_byte_flag ? RFBW_D6 : RFBW_D5; // [R13]
            end
          endcase
        end
      end
      RFBW_D1, RFBW_D2, RFBW_D3, RFBW_D4, RFBW_D5, RFBW_D6: begin
        if (w.done && wait_n) begin
          state_nxt = RFBW_E;                             // [R15] [R16]
        end
      end
      RFBW_E: state_nxt = RFBW_F;                         // [R18]
      RFBW_F: state_nxt = rwc ? RFBW_G : RFBW_A1;         // [R20]
      RFBW_G: state_nxt = rwc ? RFBW_G : RFBW_A1;         // [R20]
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_r <= RFBW_A1;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // Wait-state counters
  // ****************************************************************
  assign w.load      = (state_r == RFBW_B);               // [R8]
  assign w.iw_init   = instr_wait_field;
  assign w.dw_init   = data_wait_field;
  assign w.use_instr = (state_r == RFBW_D6);
  assign w.step      = is_access(state_r);                // [R12] [R13]

  rfbw_wait_cnt u_wait (
    .clock (clock),
    .rst_n (rstn),
    .w     (w)
  );

  // ****************************************************************
  // Local bus arbitration
  // ****************************************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      grant_r <= 1'b0;
    end else if (!local_bus_request) begin
      grant_r <= 1'b0;
    end else if (lock && (is_idle(state_r) || state_r == RFBW_G ||
                 (state_r == RFBW_F && !float_r))) begin
      grant_r <= 1'b1;                                    // [R3] [R18]
    end
  end
  assign local_bus_grant = grant_r;

  // Timing unit stalls a local data access from arbitration until termination
  assign tcu_remote_wait = local_data_access && !grant_r &&
                           (state_r inside {RFBW_B, RFBW_C} ||
                            is_access(state_r));          // [R6]

  // ****************************************************************
  // Bus float, from the clock arbitration starts (state RFBW_B)
  // ****************************************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      float_r <= 1'b0;
    end else begin
      float_r <= (state_nxt inside {RFBW_B, RFBW_C, RFBW_E, RFBW_F}) ||
                 is_access(state_nxt);                    // [R7] [R18]
    end
  end
  assign bus_drive_en = !float_r && !(state_r == RFBW_F);

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_comb begin
    transfer_acknowledge = 1'b1;
    if (state_r inside {RFBW_B, RFBW_C} || is_access(state_r)) begin
      transfer_acknowledge = 1'b0;                        // [R8]
    end else if (is_idle(state_r) && rwc) begin
      transfer_acknowledge = 1'b0;                        // [R4]
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      local_bus_ownership_n <= 1'b0;
      mem_write_n           <= 1'b1;
      instr_write_strobe_n  <= 1'b1;
    end else begin
      local_bus_ownership_n <= state_nxt inside {RFBW_C, RFBW_E} ||
                               is_access(state_nxt);      // [R8] [R16]
      mem_write_n <= !(state_nxt == RFBW_D4);             // [R12] [R22]
      instr_write_strobe_n <= !((state_nxt == RFBW_C && !cmd &&
                                ms == MS_INSTRUCTION_MEMORY && high_byte_flag) ||
                               state_nxt == RFBW_D6);     // [R9] [R13]
    end
  end

  // ****************************************************************
  // Instruction byte pairing and program counter
  // ****************************************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      instr_low_holding_latch_r     <= INSTR_LOW_HOLDING_LATCH_RST;
      instr_word <= '0;
      wrote_hi_r <= 1'b0;
    end else begin
      if (state_r == RFBW_C && state_nxt == RFBW_D5) begin
        instr_low_holding_latch_r <= ad_in;                                  // [R13]
      end
      if (state_r == RFBW_C && state_nxt == RFBW_D6) begin
        instr_word <= {ad_in, instr_low_holding_latch_r};                    // [R13]
      end
      if (state_r == RFBW_C) begin
        wrote_hi_r <= (state_nxt == RFBW_D6);
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      high_byte_flag <= 1'b0;                             // [R14]
    end else if (ric_pend_v_r && state_r == RFBW_F &&
                 ric_pend_r[RIC_MS_LSB +: 2] == MS_INSTRUCTION_MEMORY) begin
      high_byte_flag <= 1'b0;                             // [R14]
    end else if (state_r == RFBW_E &&
                 (wrote_hi_r || high_byte_flag == 1'b0) &&
                 !cmd && ms == MS_INSTRUCTION_MEMORY) begin
      high_byte_flag <= !high_byte_flag;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      program_counter <= PC_RST;
    end else if (state_r == RFBW_C && state_nxt == RFBW_D2) begin
      program_counter[7:0] <= ad_in;                      // [R11]
    end else if (state_r == RFBW_C && state_nxt == RFBW_D3) begin
      program_counter[15:8] <= ad_in;                     // [R11]
    end else if (state_r == RFBW_F && wrote_hi_r) begin
      program_counter <= program_counter + 16'h0001;      // [R19]
    end
  end

  // ****************************************************************
  // Control register, applied one T-state after the write ends
  // ****************************************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ric_pend_r   <= RIC_RST;
      ric_pend_v_r <= 1'b0;
      remote_interface_control_reg <= RIC_RST;
    end else begin
      if (state_r == RFBW_C && cmd) begin
        ric_pend_r   <= ad_in;                            // [R10]
        ric_pend_v_r <= 1'b1;
      end else if (state_r == RFBW_F && ric_pend_v_r) begin
        remote_interface_control_reg <= ric_pend_r;       // [R10]
        ric_pend_v_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_arb;
    state_r == RFBW_B ##1 state_r == RFBW_C;
  endsequence

  a_idle_stays: assert property (@(posedge clock) disable iff (!rstn) // [R1]
    is_idle(state_r) && !rwc |=> state_r == RFBW_A1)
    else $error("idle left without remote write");
  a_ovr_hold: assert property (@(posedge clock) disable iff (!rstn) // [R2]
    is_idle(state_r) && rwc && local_override_bit |=> state_r == RFBW_A2)
    else $error("override not honoured");
  a_ack_low: assert property (@(posedge clock) disable iff (!rstn) // [R4]
    is_idle(state_r) && rwc |-> !transfer_acknowledge)
    else $error("acknowledge not low");
  a_arb_seq: assert property (@(posedge clock) disable iff (!rstn) // [R8]
    state_r == RFBW_B |-> s_arb ##0 local_bus_ownership_n)
    else $error("ownership not taken");
  a_no_grant: assert property (@(posedge clock) disable iff (!rstn) // [R5]
    state_r inside {RFBW_C, RFBW_E} |-> !$rose(local_bus_grant))
    else $error("grant during remote access");
  a_term_ack: assert property (@(posedge clock) disable iff (!rstn) // [R16]
    state_r == RFBW_E |-> transfer_acknowledge && local_bus_ownership_n
    ##1 !local_bus_ownership_n)
    else $error("termination outputs wrong");
  a_data_memory_ack: assert property (@(posedge clock) disable iff (!rstn) // [R22]
    $rose(transfer_acknowledge) && $past(state_r) == RFBW_D4
    |-> $rose(mem_write_n))
    else $error("strobe and acknowledge apart");
  a_wait_ext: assert property (@(posedge clock) disable iff (!rstn) // [R15]
    is_access(state_r) && !wait_n |=> is_access(state_r))
    else $error("wait not honoured");
  a_pc_inc: assert property (@(posedge clock) disable iff (!rstn) // [R19]
    state_r == RFBW_F && wrote_hi_r
    |=> program_counter == $past(program_counter) + 16'h0001)
    else $error("pc not incremented");
  a_ack_hold: assert property (@(posedge clock) disable iff (!rstn) // [R8]
    state_r == RFBW_C |-> !transfer_acknowledge && local_bus_ownership_n)
    else $error("access start outputs wrong");
  a_lock_grant: assert property (@(posedge clock) disable iff (!rstn) // [R3]
    !lock |=> !$rose(local_bus_grant))
    else $error("grant while unlocked");
  a_float_bus: assert property (@(posedge clock) disable iff (!rstn) // [R7]
    state_r inside {RFBW_B, RFBW_F} |-> !bus_drive_en)
    else $error("buses driven during handover");
  a_iwr_start: assert property (@(posedge clock) disable iff (!rstn) // [R9]
    state_r == RFBW_C && !cmd && ms == MS_INSTRUCTION_MEMORY && high_byte_flag
    |-> !instr_write_strobe_n)
    else $error("instruction strobe missing");
  a_data_memory_strobe: assert property (@(posedge clock) disable iff (!rstn) // [R12]
    state_r == RFBW_D4 |-> !mem_write_n)
    else $error("data strobe missing");
  a_tcu_wait: assert property (@(posedge clock) disable iff (!rstn) // [R6]
    local_data_access && !local_bus_grant &&
    state_r inside {RFBW_B, RFBW_C} |-> tcu_remote_wait)
    else $error("timing unit not held");
  a_ric_apply: assert property (@(posedge clock) disable iff (!rstn) // [R10]
    state_r == RFBW_F && ric_pend_v_r
    |=> remote_interface_control_reg == $past(ric_pend_r))
    else $error("control register not applied");
  a_hib_clear: assert property (@(posedge clock) disable iff (!rstn) // [R14]
    state_r == RFBW_F && ric_pend_v_r &&
    ric_pend_r[RIC_MS_LSB +: 2] == MS_INSTRUCTION_MEMORY |=> !high_byte_flag)
    else $error("byte flag not cleared");
  a_hold_exit: assert property (@(posedge clock) disable iff (!rstn) // [R20]
    state_r inside {RFBW_F, RFBW_G} && !rwc |=> state_r == RFBW_A1)
    else $error("hold not left");

endmodule

// >>> rfbw_pkg.sv
package rfbw_pkg;

  // ****************************************************************
  // Field widths and encodings
  // ****************************************************************
  localparam int IW_W = 2;
  localparam int DW_W = 3;
  localparam logic [1:0] MS_DATA_MEMORY = 2'h0;
  localparam logic [1:0] MS_INSTRUCTION_MEMORY = 2'h1;
  localparam logic [1:0] MS_PCLO = 2'h2;
  localparam logic [1:0] MS_PCHI = 2'h3;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0]  RIC_RST   = 8'h00;
  localparam logic [15:0] PC_RST    = 16'h0000;
  localparam logic [7:0]  INSTR_LOW_HOLDING_LATCH_RST  = 8'h00;

  // Remote control register field positions
  localparam int RIC_MS_LSB = 0;
  localparam int RIC_LOR    = 2;

  // Half T-state at 125 MHz rounds to one clock of delay
  localparam int T_STATE_NS  = 8;
  localparam int CLK_NS      = 8;
  localparam int TSTATE_CYC  = (T_STATE_NS + CLK_NS - 1) / CLK_NS;

  typedef enum {
    RFBW_A1, RFBW_A2, RFBW_B, RFBW_C, RFBW_D1, RFBW_D2, RFBW_D3,
    RFBW_D4, RFBW_D5, RFBW_D6, RFBW_E, RFBW_F, RFBW_G
  } rfbw_state_t;

endpackage

// >>> rfbw_wait_if.sv
`timescale 1ns/1ns
interface rfbw_wait_if;
  import rfbw_pkg::*;
  logic            load;
  logic [IW_W-1:0] iw_init;
  logic [DW_W-1:0] dw_init;
  logic            use_instr;
  logic            step;
  logic            done;
  modport ctl (output load, iw_init, dw_init, use_instr, step, input done);
  modport cnt (input load, iw_init, dw_init, use_instr, step, output done);
endinterface

// >>> rfbw_wait_cnt.sv
`timescale 1ns/1ns
module rfbw_wait_cnt
  import rfbw_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_n,
  rfbw_wait_if.cnt  w
);

  logic [IW_W-1:0] iw_r;
  logic [DW_W-1:0] dw_r;

  // ****************************************************************
  // Wait-state counters
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      iw_r <= '0;
      dw_r <= '0;
    end else if (w.load) begin
      iw_r <= w.iw_init;
      dw_r <= w.dw_init;
    end else if (w.step) begin
      if (w.use_instr && iw_r != '0) begin
        iw_r <= iw_r - IW_W'(1);
      end
      if (!w.use_instr && dw_r != '0) begin
        dw_r <= dw_r - DW_W'(1);
      end
    end
  end

  assign w.done = w.use_instr ? (iw_r == '0) : (dw_r == '0);

endmodule

// >>> rfbw_remote_model.sv
`timescale 1ns/1ns
module rfbw_remote_model (
  input  wire logic       clock,
  input  wire logic       transfer_acknowledge,
  output logic            remote_enable,
  output logic            remote_write_strobe_n,
  output logic            cmd,
  output logic            wait_n,
  output logic [7:0]      ad_in
);
  // ****************************************************************
  // Remote processor write cycle
  // ****************************************************************
  initial begin
    remote_enable         = 1'b0;
    remote_write_strobe_n = 1'b1;
    cmd                   = 1'b0;
    wait_n                = 1'b1;
    ad_in                 = 8'h5a;
  end

  // Wait is raised once acknowledge has been low for rel cycles
  task automatic write(input logic c, input logic [7:0] d, input int rel,
                       input int hold, input int lim, output logic done,
                       output int n);
    int k;
    begin
      n = 0;
      done = 1'b0;
      @(posedge clock);
      remote_enable <= 1'b1;
      remote_write_strobe_n <= 1'b0;
      cmd <= c;
      ad_in <= d;
      wait_n <= (rel == 0);
      for (k = 0; k < lim && !done; k++) begin
        @(posedge clock);
        if (transfer_acknowledge === 1'b0)
          n++;
        if (n == rel)
          wait_n <= 1'b1;
        if (transfer_acknowledge === 1'b1 && n > 0)
          done = 1'b1;
      end
      repeat (hold) @(posedge clock);
      remote_enable <= 1'b0;
      remote_write_strobe_n <= 1'b1;
      wait_n <= 1'b1;
      ad_in <= ~d;
      cmd <= ~c;
      @(posedge clock);
    end
  endtask
endmodule

// >>> remote_fast_buffered_write_tb.sv
`timescale 1ns/1ns
module remote_fast_buffered_write_tb;
  import rfbw_pkg::*;
  logic clock, rst_n, remote_enable, remote_write_strobe_n, cmd, wait_n;
  logic local_bus_request, lock, local_data_access;
  logic [7:0] ad_in, remote_interface_control_reg;
  logic [IW_W-1:0] instr_wait_field;
  logic [DW_W-1:0] data_wait_field;
  logic transfer_acknowledge, local_bus_ownership_n, local_bus_grant;
  logic tcu_remote_wait, bus_drive_en, mem_write_n, instr_write_strobe_n;
  logic high_byte_flag, dn;
  logic [15:0] instr_word, program_counter;
  int mismatches, total_checks, cycles, ack_lo, wr_lo, iwr_lo, nn;
  int bad_grant, bad_drive, bad_stall;
  int dws[3] = '{0, 3, 7};

  rfbw_access_sm u_rfbw_access_sm (
    .clock(clock), .rst_n(rst_n), .remote_enable(remote_enable),
    .remote_write_strobe_n(remote_write_strobe_n), .cmd(cmd),
    .wait_n(wait_n), .local_bus_request(local_bus_request), .lock(lock),
    .local_data_access(local_data_access), .ad_in(ad_in),
    .instr_wait_field(instr_wait_field),
    .data_wait_field(data_wait_field),
    .transfer_acknowledge(transfer_acknowledge),
    .local_bus_ownership_n(local_bus_ownership_n),
    .local_bus_grant(local_bus_grant), .tcu_remote_wait(tcu_remote_wait),
    .bus_drive_en(bus_drive_en), .mem_write_n(mem_write_n),
    .instr_write_strobe_n(instr_write_strobe_n), .instr_word(instr_word),
    .program_counter(program_counter),
    .remote_interface_control_reg(remote_interface_control_reg),
    .high_byte_flag(high_byte_flag));
  rfbw_remote_model u_rfbw_remote_model (
    .clock(clock), .transfer_acknowledge(transfer_acknowledge),
    .remote_enable(remote_enable),
    .remote_write_strobe_n(remote_write_strobe_n), .cmd(cmd),
    .wait_n(wait_n), .ad_in(ad_in));

  // ****************************************************************
  // Clock, monitor and timeout
  // ****************************************************************
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (transfer_acknowledge === 1'b0) ack_lo++;
    if (mem_write_n === 1'b0) wr_lo++;
    if (instr_write_strobe_n === 1'b0) iwr_lo++;
    if (local_bus_ownership_n === 1'b1 && bus_drive_en !== 1'b0)
      bad_drive++;
    if (local_bus_ownership_n === 1'b1 && transfer_acknowledge === 1'b0 &&
        local_bus_grant !== 1'b0)
      bad_grant++;
    if (mem_write_n === 1'b0 && local_data_access &&
        tcu_remote_wait !== 1'b1)
      bad_stall++;
    if (cycles == 5000) begin
      mismatches++;
      summarize();
    end
  end

  // ****************************************************************
  // Compare and transfer tasks
  // ****************************************************************
  task automatic chk_vec(input string nm, input logic [15:0] seen,
                         input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic chk_int(input string nm, input int seen, input int exp);
    total_checks++;
    if (seen != exp) begin
      mismatches++;
      $display("Error %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask

  task automatic xfer(input logic c, input logic [7:0] d, input int rel,
                      input int hold);
    begin
      ack_lo = 0;
      wr_lo = 0;
      iwr_lo = 0;
      u_rfbw_remote_model.write(c, d, rel, hold, 200, dn, nn);
      @(posedge clock);
      #1;
      chk_vec("done", 16'(dn), 16'h1);
    end
  endtask

  task automatic summarize();
    $display("Checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    rst_n = 1'b0;
    lock = 1'b1;
    local_bus_request = 1'b0;
    local_data_access = 1'b0;
    instr_wait_field = 2'h2;
    data_wait_field = 3'h0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    #1;
    chk_vec("ack_rst", 16'(transfer_acknowledge), 16'h1);
    chk_vec("own_rst", 16'(local_bus_ownership_n), 16'h0);
    chk_vec("ric_rst", 16'(remote_interface_control_reg), 16'(RIC_RST));
    chk_vec("pc_rst", program_counter, PC_RST);
    chk_vec("hib_rst", 16'(high_byte_flag), 16'h0);
    local_data_access <= 1'b1;
    foreach (dws[i]) begin
      data_wait_field <= dws[i][DW_W-1:0];
      xfer(1'b0, 8'h10, 0, 0);
      chk_int("ack_low", ack_lo, 4 + dws[i]);
      chk_int("wr_low", wr_lo, 1 + dws[i]);
    end
    local_data_access <= 1'b0;
    data_wait_field <= 3'h1;
    xfer(1'b0, 8'h20, 6, 0);
    chk_int("ack_wait", ack_lo, 7);
    chk_int("wr_wait", wr_lo, 4);
    @(posedge clock) local_bus_request <= 1'b1;
    lock <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    chk_vec("grant_lock", 16'(local_bus_grant), 16'h0);
    @(posedge clock) lock <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk_vec("grant_idle", 16'(local_bus_grant), 16'h1);
    fork
      xfer(1'b0, 8'h11, 0, 0);
      begin
        repeat (10) @(posedge clock);
        #1;
        chk_vec("own_held", 16'(local_bus_ownership_n), 16'h0);
        chk_vec("ack_held", 16'(transfer_acknowledge), 16'h0);
        @(posedge clock) local_bus_request <= 1'b0;
      end
    join
    @(posedge clock) local_bus_request <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk_vec("grant_after", 16'(local_bus_grant), 16'h1);
    @(posedge clock) local_bus_request <= 1'b0;
    xfer(1'b0, 8'h22, 0, 5);
    xfer(1'b0, 8'h23, 0, 0);
    xfer(1'b1, 8'h02, 0, 0);
    chk_vec("ric", 16'(remote_interface_control_reg), 16'h2);
    xfer(1'b0, 8'h34, 0, 0);
    xfer(1'b1, 8'h03, 0, 0);
    xfer(1'b0, 8'h12, 0, 0);
    chk_vec("pc", program_counter, 16'h1234);
    xfer(1'b1, 8'h01, 0, 0);
    chk_vec("hib_sel", 16'(high_byte_flag), 16'h0);
    xfer(1'b0, 8'haa, 0, 0);
    chk_vec("hib_lo", 16'(high_byte_flag), 16'h1);
    chk_int("iwr_lo", iwr_lo, 0);
    xfer(1'b0, 8'hbb, 0, 0);
    chk_int("iwr_hi", iwr_lo > 0, 1);
    chk_vec("iword", instr_word, 16'hbbaa);
    chk_vec("pc_inc", program_counter, 16'h1235);
    chk_vec("hib_hi", 16'(high_byte_flag), 16'h0);
    xfer(1'b0, 8'hcc, 0, 0);
    xfer(1'b1, 8'h01, 0, 0);
    chk_vec("hib_realign", 16'(high_byte_flag), 16'h0);
    xfer(1'b0, 8'hcd, 0, 0);
    xfer(1'b1, 8'h04, 0, 0);
    u_rfbw_remote_model.write(1'b0, 8'h44, 0, 0, 30, dn, nn);
    #1;
    chk_vec("lor_block", 16'(dn), 16'h0);
    chk_vec("lor_own", 16'(local_bus_ownership_n), 16'h0);
    @(posedge clock) rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    #1;
    chk_vec("ric_reset", 16'(remote_interface_control_reg), 16'h0);
    chk_vec("hib_reset", 16'(high_byte_flag), 16'h0);
    chk_int("grant_busy", bad_grant, 0);
    chk_int("bus_float", bad_drive, 0);
    chk_int("tcu_stall", bad_stall, 0);
    summarize();
  end
endmodule
